// [common/mac_chw_defs.svh]
// Constants of the cross-halfword multiply-accumulate unit.
// Assumes bit 0 is the least significant bit of every word.
`ifndef MAC_CHW_DEFS_SVH
`define MAC_CHW_DEFS_SVH

// ==========================================================
// Instruction fields
`define PRIM_OP_HI 31
`define PRIM_OP_LO 26
`define PRIM_OP_FAMILY 6'h04
`define TGT_IDX_HI 25
`define TGT_IDX_LO 21
`define OE_BIT 10
`define XO_HI 9
`define XO_LO 1
`define REC_BIT 0
`define XO_SIGNED_MOD 9'h0AC
`define XO_SIGNED_SAT 9'h0EC
`define XO_UNSIGNED_SAT 9'h0CC
`define XO_UNSIGNED_MOD 9'h08C

// ==========================================================
// Operand halfwords
`define HALF_A_HI 15
`define HALF_A_LO 0
`define HALF_B_HI 31
`define HALF_B_LO 16

// ==========================================================
// Saturation values
`define SAT_U_MAX 32'hFFFFFFFF
`define SAT_S_MAX 32'h7FFFFFFF
`define SAT_S_MIN 32'h80000000

// ==========================================================
// Condition field layout
`define CFZ_LT 3
`define CFZ_GT 2
`define CFZ_EQ 1
`define CFZ_SO 0

// ==========================================================
// Register offsets and fields
`define REG_FXER 8'h00
`define REG_CFZ 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0C
`define REG_RESULT 8'h10
`define FXER_OVF_BIT 0
`define FXER_SUM_BIT 1
`define EVT_OVF 0
`define EVT_SAT 1
`define EVT_FOREIGN 2
`define EVT_W 3

// ==========================================================
// Reset values
`define FXER_RST 2'h0
`define CFZ_RST 4'h0
`define EVT_RST 3'h0
`define WORD_RST 32'h00000000
`define IDX_RST 5'h00
`define FLAG_RST 1'b0

`endif

// [common/mac_chw_pkg.sv]
// Types shared by the multiply-accumulate unit files.
// Assumes the constants header is compiled alongside.
package mac_chw_pkg;

  // ==========================================================
  // Arithmetic variants
  typedef enum logic [2:0] {
    VAR_NONE,
    VAR_SIGNED_MOD,
    VAR_SIGNED_SAT,
    VAR_UNSIGNED_SAT,
    VAR_UNSIGNED_MOD
  } mac_variant_t;

endpackage

// [hw/irq_status_block.sv]
// Sticky event status, mask and level interrupt.
// Assumes events are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`include "mac_chw_defs.svh"

module irq_status_block
  import mac_chw_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [`EVT_W-1:0] event_i,
  input wire logic clear_i,
  input wire logic mask_we_i,
  input wire logic [`EVT_W-1:0] mask_wdata_i,
  output logic [`EVT_W-1:0] status_o,
  output logic [`EVT_W-1:0] mask_o,
  output logic irq_o
);

  logic [`EVT_W-1:0] status_q;
  logic [`EVT_W-1:0] status_d;
  logic [`EVT_W-1:0] mask_q;

  // ==========================================================
  // Status
  // An event in the clearing read's cycle survives the clear
  assign status_d = (clear_i ? `EVT_RST : status_q) | event_i;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      status_q <= `EVT_RST;
      mask_q <= `EVT_RST;
    end
    else
    begin
      status_q <= status_d;
      if (mask_we_i)
      begin
        mask_q <= mask_wdata_i;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = |(status_q & mask_q);

endmodule

// [hw/mac_cross_halfword_unit.sv]
// Cross-halfword multiply-accumulate datapath with flags and registers.
// Assumes decode and register file present operands with issue_valid_i
// and accept the write-back one cycle later.
//
// Contract
// - Multiply low half A by high half B.
// - Signed modulo: low 32 bits of sum.
// - Signed saturating clamps to 32-bit signed limits.
// - Overflow: same signs in, sum sign flips.
// - Unsigned saturating: carry out gives all ones.
// - Unsigned modulo: low 32 bits of sum.
// - Decode family opcode and field positions.
// - Record bit set updates condition field.
// - Overflow enable updates the overflow flags.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "mac_chw_defs.svh"

module mac_cross_halfword_unit
  import mac_chw_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] source_a_register_i,
  input wire logic [31:0] source_b_register_i,
  input wire logic [31:0] target_register_i,
  output logic wb_valid_o,
  output logic [4:0] wb_index_o,
  output logic [31:0] wb_data_o,
  output logic [3:0] condition_field_zero_o,
  output logic overflow_flag_o,
  output logic summary_overflow_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);

  // ==========================================================
  // Functions
  function automatic mac_variant_t decode_variant(input logic [31:0] w);
    mac_variant_t v;
    v = VAR_NONE;
    if (w[`PRIM_OP_HI:`PRIM_OP_LO] == `PRIM_OP_FAMILY)
    begin
      case (w[`XO_HI:`XO_LO])
        `XO_SIGNED_MOD: v = VAR_SIGNED_MOD;
        `XO_SIGNED_SAT: v = VAR_SIGNED_SAT;
        `XO_UNSIGNED_SAT: v = VAR_UNSIGNED_SAT;
        `XO_UNSIGNED_MOD: v = VAR_UNSIGNED_MOD;
        default: v = VAR_NONE;
      endcase
    end
    return v;
  endfunction

  function automatic logic [3:0] cr_encode(input logic [31:0] v, input logic so);
    logic [3:0] f;
    f = `CFZ_RST;
    f[`CFZ_LT] = v[31];
    f[`CFZ_GT] = !v[31] && (v != `WORD_RST);
    f[`CFZ_EQ] = (v == `WORD_RST);
    f[`CFZ_SO] = so;
    return f;
  endfunction

  // ==========================================================
  // Decode
  mac_variant_t variant_w;
  logic issue_hit_w;
  logic issue_miss_w;
  logic oe_w;
  logic record_bit_w;
  logic [4:0] tgt_idx_w;
  logic is_signed_w;
  logic is_sat_w;

  assign variant_w = decode_variant(instr_i);
  assign issue_hit_w = issue_valid_i && (variant_w != VAR_NONE);
  assign issue_miss_w = issue_valid_i && (variant_w == VAR_NONE);
  assign oe_w = instr_i[`OE_BIT];
  assign record_bit_w = instr_i[`REC_BIT];
  assign tgt_idx_w = instr_i[`TGT_IDX_HI:`TGT_IDX_LO];
  assign is_signed_w = (variant_w == VAR_SIGNED_MOD) || (variant_w == VAR_SIGNED_SAT);
  assign is_sat_w = (variant_w == VAR_SIGNED_SAT) || (variant_w == VAR_UNSIGNED_SAT);

  // ==========================================================
  // Product and sum
  logic [15:0] half_a_w;
  logic [15:0] half_b_w;
  logic signed [31:0] ext_a_w;
  logic signed [31:0] ext_b_w;
  logic signed [31:0] prod_s_w;
  logic [31:0] prod_u_w;
  logic [31:0] prod_w;
  logic [32:0] sum_w;

  assign half_a_w = source_a_register_i[`HALF_A_HI:`HALF_A_LO];
  assign half_b_w = source_b_register_i[`HALF_B_HI:`HALF_B_LO];
  assign ext_a_w = {{16{half_a_w[15]}}, half_a_w};
  assign ext_b_w = {{16{half_b_w[15]}}, half_b_w};
  // A 16 by 16 product always fits 32 bits, so no bits are lost here
  assign prod_s_w = ext_a_w * ext_b_w;
  assign prod_u_w = {16'h0000, half_a_w} * {16'h0000, half_b_w};
  assign prod_w = is_signed_w ? prod_s_w : prod_u_w;
  assign sum_w = {1'b0, prod_w} + {1'b0, target_register_i};

  // ==========================================================
  // Overflow detection and result selection
  logic s_unrep_w;
  logic u_unrep_w;
  logic unrep_w;
  logic [31:0] sat_s_w;
  logic [31:0] result_w;

  assign s_unrep_w = (prod_w[31] == target_register_i[31]) &&
                     (sum_w[31] != target_register_i[31]);
  assign u_unrep_w = sum_w[32];
  assign unrep_w = is_signed_w ? s_unrep_w : u_unrep_w;
  assign sat_s_w = {target_register_i[31], {31{~target_register_i[31]}}};

  assign result_w =
    (variant_w == VAR_SIGNED_SAT && s_unrep_w) ? sat_s_w :
    (variant_w == VAR_UNSIGNED_SAT && u_unrep_w) ? `SAT_U_MAX :
    sum_w[31:0];

  // ==========================================================
  // Register bus decode
  logic fxer_we_w;
  logic mask_we_w;
  logic status_clr_w;

  assign fxer_we_w = reg_we_i && (reg_addr_i == `REG_FXER);
  assign mask_we_w = reg_we_i && (reg_addr_i == `REG_MASK);
  assign status_clr_w = reg_re_i && (reg_addr_i == `REG_STATUS);

  // ==========================================================
  // Fixed-point exception flags
  logic overflow_flag_q;
  logic overflow_flag_d;
  logic summary_q;
  logic summary_d;
  logic flag_upd_w;

  assign flag_upd_w = issue_hit_w && oe_w;
  // Instruction update beats a software write in the same cycle; for summary only when the op overflows
  assign overflow_flag_d = flag_upd_w ? unrep_w :
                           fxer_we_w ? reg_wdata_i[`FXER_OVF_BIT] :
                           overflow_flag_q;
  assign summary_d = (flag_upd_w && unrep_w) ? 1'b1 :
                     fxer_we_w ? reg_wdata_i[`FXER_SUM_BIT] :
                     summary_q;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      overflow_flag_q <= `FLAG_RST;
      summary_q <= `FLAG_RST;
    end
    else
    begin
      overflow_flag_q <= overflow_flag_d;
      summary_q <= summary_d;
    end
  end

  // ==========================================================
  // Condition field zero
  logic [3:0] cfz_q;
  logic [3:0] cfz_d;

  assign cfz_d = (issue_hit_w && record_bit_w) ?
                 cr_encode(result_w, summary_d) : cfz_q;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cfz_q <= `CFZ_RST;
    end
    else
    begin
      cfz_q <= cfz_d;
    end
  end

  // ==========================================================
  // Write-back
  logic wb_valid_q;
  logic [4:0] wb_index_q;
  logic [31:0] wb_data_q;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wb_valid_q <= 1'b0;
      wb_index_q <= `IDX_RST;
      wb_data_q <= `WORD_RST;
    end
    else
    begin
      wb_valid_q <= issue_hit_w;
      if (issue_hit_w)
      begin
        wb_index_q <= tgt_idx_w;
        wb_data_q <= result_w;
      end
    end
  end

  // ==========================================================
  // Interrupt events
  logic [`EVT_W-1:0] events_w;
  logic [`EVT_W-1:0] status_w;
  logic [`EVT_W-1:0] mask_w;

  assign events_w[`EVT_OVF] = issue_hit_w && unrep_w;
  assign events_w[`EVT_SAT] = issue_hit_w && is_sat_w && unrep_w;
  // Foreign words are dropped silently; only this event tells software
  assign events_w[`EVT_FOREIGN] = issue_miss_w;

  irq_status_block u_irq
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .event_i(events_w),
    .clear_i(status_clr_w),
    .mask_we_i(mask_we_w),
    .mask_wdata_i(reg_wdata_i[`EVT_W-1:0]),
    .status_o(status_w),
    .mask_o(mask_w),
    .irq_o(irq_o)
  );

  // ==========================================================
  // Register read
  logic [31:0] rd_mux_w;
  logic [31:0] rdata_q;

  assign rd_mux_w =
    (reg_addr_i == `REG_FXER) ? {30'h0, summary_q, overflow_flag_q} :
    (reg_addr_i == `REG_CFZ) ? {28'h0, cfz_q} :
    (reg_addr_i == `REG_STATUS) ? {29'h0, status_w} :
    (reg_addr_i == `REG_MASK) ? {29'h0, mask_w} :
    (reg_addr_i == `REG_RESULT) ? wb_data_q :
    `WORD_RST;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_q <= `WORD_RST;
    end
    else
    begin
      rdata_q <= reg_re_i ? rd_mux_w : `WORD_RST;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_valid_o = wb_valid_q;
  assign wb_index_o = wb_index_q;
  assign wb_data_o = wb_data_q;
  assign condition_field_zero_o = cfz_q;
  assign overflow_flag_o = overflow_flag_q;
  assign summary_overflow_o = summary_q;
  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // Checks
  logic [31:0] ref_u_w;
  logic signed [31:0] ref_s_w;
  logic [31:0] ref_s_sum_w;
  logic [32:0] ref_u_sum_w;

  // Reference built from the raw ports, not from the datapath wires
  assign ref_u_w = {16'h0000, source_a_register_i[15:0]} *
                   {16'h0000, source_b_register_i[31:16]};
  assign ref_s_w = {{16{source_a_register_i[15]}}, source_a_register_i[15:0]} *
                   {{16{source_b_register_i[31]}}, source_b_register_i[31:16]};
  assign ref_s_sum_w = ref_s_w + target_register_i;
  assign ref_u_sum_w = {1'b0, ref_u_w} + {1'b0, target_register_i};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_HALF_SELECT:
    assert property (issue_hit_w && variant_w == VAR_UNSIGNED_MOD |=>
      wb_data_o == $past(ref_u_sum_w[31:0]))
    else $error("unsigned modulo result uses wrong halfwords");

  AST_SIGNED_MOD:
    assert property (issue_hit_w && variant_w == VAR_SIGNED_MOD |=>
      wb_valid_o && wb_data_o == $past(ref_s_sum_w))
    else $error("signed modulo result wrong");

  AST_SIGNED_SAT_HI:
    assert property (issue_hit_w && variant_w == VAR_SIGNED_SAT &&
      !target_register_i[31] && !ref_s_w[31] && ref_s_sum_w[31] |=>
      wb_data_o == `SAT_S_MAX)
    else $error("positive saturation missing");

  AST_SIGNED_SAT_LO:
    assert property (issue_hit_w && variant_w == VAR_SIGNED_SAT &&
      target_register_i[31] && ref_s_w[31] && !ref_s_sum_w[31] |=>
      wb_data_o == `SAT_S_MIN)
    else $error("negative saturation missing");

  AST_UNSIGNED_SAT:
    assert property (issue_hit_w && variant_w == VAR_UNSIGNED_SAT |=>
      wb_data_o == ($past(ref_u_sum_w[32]) ? `SAT_U_MAX : $past(ref_u_sum_w[31:0])))
    else $error("unsigned saturating result wrong");

  AST_UNSIGNED_MOD_IDX:
    assert property (issue_hit_w && variant_w == VAR_UNSIGNED_MOD |=>
      wb_valid_o && wb_index_o == $past(instr_i[25:21]))
    else $error("unsigned modulo write-back missing or misdirected");

  AST_FOREIGN_DROP:
    assert property (issue_valid_i && instr_i[31:26] != 6'h04 |=> !wb_valid_o)
    else $error("foreign opcode produced a write-back");

  AST_RECORD_HOLD:
    assert property (issue_hit_w && !record_bit_w |=> $stable(condition_field_zero_o))
    else $error("condition field changed without record bit");

  AST_OE_HOLD:
    assert property (issue_hit_w && !oe_w && !fxer_we_w |=>
      $stable(overflow_flag_o) && $stable(summary_overflow_o))
    else $error("overflow flags changed without enable");

  AST_OV_VALUE:
    assert property (issue_hit_w && oe_w |=>
      overflow_flag_o == $past(unrep_w) && (!overflow_flag_o || summary_overflow_o))
    else $error("overflow or summary flag wrong");

  AST_RECORD_VALUE:
    assert property (issue_hit_w && record_bit_w |=>
      condition_field_zero_o == {wb_data_o[31],
                                 !wb_data_o[31] && (wb_data_o != `WORD_RST),
                                 wb_data_o == `WORD_RST,
                                 summary_overflow_o})
    else $error("condition field encoding wrong");

endmodule

// [verification/gpr_file_model.sv]
// Behavioural register file that feeds operands to the unit and takes write-back.
// Assumes write-back arrives one cycle after issue, as the unit promises.
`timescale 1ns/1ps

module gpr_file_model
(
  input wire logic clk_i,
  input wire logic [31:0] instr_i,
  input wire logic wb_valid_i,
  input wire logic [4:0] wb_index_i,
  input wire logic [31:0] wb_data_i,
  output logic [31:0] src_a_o,
  output logic [31:0] src_b_o,
  output logic [31:0] tgt_o
);
  // ==========================================================
  // Storage with write-back bypass
  logic [31:0] gpr_q [32];
  wire logic [4:0] idx_t = instr_i[25:21];
  wire logic [4:0] idx_a = instr_i[20:16];
  wire logic [4:0] idx_b = instr_i[15:11];

  // Bypass lets back-to-back ops on one target chain without a stall
  assign tgt_o = (wb_valid_i && wb_index_i == idx_t) ? wb_data_i : gpr_q[idx_t];
  assign src_a_o = (wb_valid_i && wb_index_i == idx_a) ? wb_data_i : gpr_q[idx_a];
  assign src_b_o = (wb_valid_i && wb_index_i == idx_b) ? wb_data_i : gpr_q[idx_b];

  always @(posedge clk_i)
  begin
    if (wb_valid_i)
      gpr_q[wb_index_i] <= wb_data_i;
  end

  task load(input logic [4:0] idx, input logic [31:0] v);
    gpr_q[idx] <= v;
  endtask
endmodule

// [verification/mac_cross_halfword_unit_test.sv]
// Self-checking bench for the cross-halfword multiply-accumulate unit.
// Assumes the register file model supplies operands and takes write-back.
`timescale 1ns/1ps
`include "mac_chw_defs.svh"

module mac_cross_halfword_unit_test;
  // ==========================================================
  // Signals
  logic clk_i = 0, nrst_i = 0, issue_valid_i = 0, reg_we_i = 0, reg_re_i = 0;
  logic [31:0] instr_i = '0, reg_wdata_i = '0;
  logic [7:0] reg_addr_i = '0;
  logic [31:0] src_a, src_b, tgt, wb_data_o, reg_rdata_o;
  logic [4:0] wb_index_o;
  logic [3:0] cfz_o;
  logic wb_valid_o, ovf_o, so_o, irq_o;
  logic so_exp = 0, ovf_exp = 0;
  logic [31:0] last_res = '0;
  int err_count = 0, num_checks = 0;
  logic [8:0] xos [4] = '{`XO_SIGNED_MOD, `XO_SIGNED_SAT, `XO_UNSIGNED_SAT, `XO_UNSIGNED_MOD};
  logic [31:0] va [4] = '{32'hFFFF0003, 32'h00007FFF, 32'h00008000, 32'h0000FFFF};
  logic [31:0] vb [4] = '{32'h00051234, 32'h7FFF0000, 32'h7FFF0000, 32'hFFFF0000};
  logic [31:0] vt [4] = '{32'h0000000A, 32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF};

  always #20 clk_i = ~clk_i;

  mac_cross_halfword_unit i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .issue_valid_i(issue_valid_i), .instr_i(instr_i), .source_a_register_i(src_a),
    .source_b_register_i(src_b), .target_register_i(tgt), .wb_valid_o(wb_valid_o),
    .wb_index_o(wb_index_o), .wb_data_o(wb_data_o), .condition_field_zero_o(cfz_o),
    .overflow_flag_o(ovf_o), .summary_overflow_o(so_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

  gpr_file_model i_rf (.clk_i(clk_i), .instr_i(instr_i), .wb_valid_i(wb_valid_o),
    .wb_index_i(wb_index_o), .wb_data_i(wb_data_o), .src_a_o(src_a), .src_b_o(src_b),
    .tgt_o(tgt));

  // ==========================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] mk(input logic [8:0] xo, input logic [4:0] rt, ra, rb,
                                     input logic oe, rc);
    return {`PRIM_OP_FAMILY, rt, ra, rb, oe, xo, rc};
  endfunction

  // Returns the overflow indication above the 32-bit result
  function automatic logic [32:0] ref_mac(input logic [8:0] xo, input logic [31:0] a, b, t);
    logic signed [31:0] ps;
    logic [31:0] pu, ss;
    logic [32:0] su;
    logic ov;
    ps = $signed(a[15:0]) * $signed(b[31:16]);
    pu = a[15:0] * b[31:16];
    ss = ps + t;
    su = {1'b0, pu} + {1'b0, t};
    if (xo == `XO_SIGNED_MOD || xo == `XO_SIGNED_SAT)
    begin
      ov = (ps[31] == t[31]) && (ss[31] != t[31]);
      if (xo == `XO_SIGNED_SAT && ov)
        ss = {t[31], {31{~t[31]}}};
      return {ov, ss};
    end
    ov = su[32];
    if (xo == `XO_UNSIGNED_SAT && ov)
      return {ov, `SAT_U_MAX};
    return {ov, su[31:0]};
  endfunction

  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task reg_rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
    @(posedge clk_i);
  endtask

  // One op with fixed sources 1 and 2, judged in the write-back cycle
  task automatic run_op(input logic [8:0] xo, input logic [4:0] rt, input logic [31:0] a, b,
                        t, input logic oe, rc);
    logic [32:0] r;
    logic [3:0] cf;
    issue_valid_i <= 1'b1;
    instr_i <= mk(xo, rt, 5'h01, 5'h02, oe, rc);
    // Operands go in after the previous write-back has landed in the file
    #1;
    i_rf.load(5'h01, a);
    i_rf.load(5'h02, b);
    i_rf.load(rt, t);
    r = ref_mac(xo, a, b, t);
    cf = cfz_o;
    @(posedge clk_i);
    issue_valid_i <= 1'b0;
    #1;
    if (oe)
    begin
      ovf_exp = r[32];
      so_exp = so_exp | r[32];
    end
    last_res = r[31:0];
    check(wb_valid_o, 1);
    check(wb_index_o, rt);
    check(wb_data_o, r[31:0]);
    check(ovf_o, ovf_exp);
    check(so_o, so_exp);
    check(cfz_o, rc ? {$signed(r[31:0]) < 0, $signed(r[31:0]) > 0, r[31:0] == 0, so_exp} : cf);
    @(posedge clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task test_variants;
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 4; j++)
        run_op(xos[i], 5'(i * 4 + j + 3), va[j], vb[j], vt[j], 1'b1, 1'b1);
    $display("test_variants done");
  endtask

  task test_enables;
    for (int k = 0; k < 3; k++)
      run_op(`XO_SIGNED_MOD, 5'h1F, va[1], vb[1], vt[1], k[1], k[0]);
    $display("test_enables done");
  endtask

  task test_regs;
    check(irq_o, 0);
    reg_rd(`REG_STATUS, 32'h3);
    reg_rd(`REG_STATUS, 32'h0);
    reg_rd(`REG_FXER, {30'h0, so_exp, ovf_exp});
    reg_wr(`REG_RESULT, 32'h0000ABCD);
    reg_rd(`REG_RESULT, last_res);
    reg_rd(8'h20, 32'h0);
    reg_wr(`REG_MASK, 32'h4);
    reg_rd(`REG_MASK, 32'h4);
    issue_valid_i <= 1'b1;
    instr_i <= 32'h7C000000;
    @(posedge clk_i);
    issue_valid_i <= 1'b0;
    #1;
    check(wb_valid_o, 0);
    check(irq_o, 1);
    @(posedge clk_i);
    reg_rd(`REG_STATUS, 32'h4);
    check(irq_o, 0);
    reg_wr(`REG_FXER, 32'h0);
    reg_rd(`REG_FXER, 32'h0);
    check(so_o, 0);
    $display("test_regs done");
  endtask

  // Overflowing op, then a clean one on the same target in the next cycle
  task automatic test_chain;
    logic [32:0] r;
    r = ref_mac(`XO_SIGNED_SAT, 32'h7FFF, 32'h7FFF0000, 32'h7FFF0000);
    r = ref_mac(`XO_UNSIGNED_MOD, 32'h1, 32'h10000, r[31:0]);
    i_rf.load(5'h01, 32'h7FFF);
    i_rf.load(5'h02, 32'h7FFF0000);
    i_rf.load(5'h05, 32'h7FFF0000);
    i_rf.load(5'h06, 32'h1);
    i_rf.load(5'h07, 32'h10000);
    issue_valid_i <= 1'b1;
    instr_i <= mk(`XO_SIGNED_SAT, 5'h05, 5'h01, 5'h02, 1'b1, 1'b1);
    @(posedge clk_i);
    instr_i <= mk(`XO_UNSIGNED_MOD, 5'h05, 5'h06, 5'h07, 1'b1, 1'b1);
    @(posedge clk_i);
    issue_valid_i <= 1'b0;
    #1;
    check(wb_valid_o, 1);
    check(wb_data_o, r[31:0]);
    check(ovf_o, r[32]);
    check(so_o, 1);
    check(cfz_o, 4'h9);
    @(posedge clk_i);
    #1;
    check(i_rf.gpr_q[5], r[31:0]);
    @(posedge clk_i);
    $display("test_chain done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    check({wb_valid_o, ovf_o, so_o, irq_o, cfz_o}, 0);
    @(posedge clk_i);
    test_variants();
    test_enables();
    test_regs();
    test_chain();
    complete_run();
  end

  initial
  begin
    #(40 * 2000);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
